// File: inc/tmwc_pkg.sv
// Overview of operation
// - blocks 0-4 and 7-15 are rewritable user blocks, each lockable on its own
// - a protected block can never be unprotected by any command sequence
// - counters at blocks 5 and 6 accept only a strictly lower value
// - any decrement step of one or more is accepted in one write
// - counter 5 ships as fffffffe, counter 6 as ffffffff
// - a counter at zero is exhausted and can never be reloaded
// - reader writes the complete new 32-bit value to the counter block
// - power loss while programming leaves the previous value intact
// - counter blocks 5 and 6 can be locked and then act as read-only
// - writes to a protected block are ignored, contents unchanged
// - writes to blocks 7 to 15 run an erase cycle before programming
// - system block 255 is never erased; writes can only clear bits
// - system block with all 32 bits zero rejects any further update
// - bits 16 to 31 of block 255 lock blocks 0 to 15, zero locks
// - a cleared lock bit never returns to one
// - new locks take effect only at a select with matching identifier
// - fixed option holds an 8-bit select identifier in bits 7:0 of block 255
// - fixed option disables random identifier generation
// - every accepted write to blocks 0 to 15 replaces all 32 bits of the block
// - every block can be read whatever its protection state
package tmwc_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned NBLK = 16;
   localparam logic [7:0] CNT_A_ADDR = 8'h05;
   localparam logic [7:0] CNT_B_ADDR = 8'h06;
   localparam logic [7:0] AUTO_ERASE_LO = 8'h07;
   localparam logic [7:0] SYS_ADDR = 8'hff;
   localparam logic [31:0] CNT_A_RST = 32'hffff_fffe;
   localparam logic [31:0] CNT_B_RST = 32'hffff_ffff;
   localparam logic [31:0] USER_RST = 32'hffff_ffff;
   localparam logic [31:0] SYS_RST = 32'hffff_ffff;
   localparam int unsigned LOCK_LSB = 16;
   localparam int unsigned LOCK_MSB = 31;
   localparam int unsigned FACTORY_BIT = 15;
   localparam int unsigned ID_MSB = 7;
   localparam logic [7:0] ID_SEED = 8'h5a;
   // timing of the self-timed nonvolatile cycle
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned ERASE_TIME_NS = 1000;
   localparam int unsigned PROG_TIME_NS = 2000;
   localparam int unsigned ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_READ,
      OP_WRITE,
      OP_SELECT,
      OP_NEW_ID
   } tmwc_op_t;

   typedef struct packed {
      logic valid;
      tmwc_op_t op;
      logic [7:0] addr;
      logic [31:0] data;
   } tmwc_req_t;

   typedef struct packed {
      logic rd_valid;
      logic [31:0] rd_data;
      logic wr_done;
      logic sel_match;
      logic busy;
   } tmwc_rsp_t;

   // shipping contents of the sixteen blocks
   function automatic logic [15:0][31:0] tmwc_factory_mem();
      logic [15:0][31:0] m;
      for (int i = 0; i < 16; i++) begin
         m[i] = USER_RST;
      end
      m[CNT_A_ADDR[3:0]] = CNT_A_RST;
      m[CNT_B_ADDR[3:0]] = CNT_B_RST;
      return m;
   endfunction
endpackage

// File: src/tmwc_nv_seq.sv
`timescale 1ns/100ps
`default_nettype none
module tmwc_nv_seq #(
   parameter int unsigned ERASE_CYC = tmwc_pkg::ERASE_CYC,
   parameter int unsigned PROG_CYC = tmwc_pkg::PROG_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic erase_i,
   input wire logic abort_i,
   output logic busy_o,
   output logic erasing_o,
   output logic done_o
);
   localparam int unsigned CW = 16;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ERASE,
      PH_PROG
   } tmwc_ph_t;

   typedef struct packed {
      tmwc_ph_t ph;
      logic [CW-1:0] cnt;
      logic done;
   } tmwc_seq_t;

   tmwc_seq_t q;
   tmwc_seq_t d;

   // erase (only when erase_i) then program, each a fixed count; abort drops back to idle
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (abort_i) begin
         d.ph = PH_IDLE;
         d.cnt = '0;
      end else begin
         unique case (q.ph)
            PH_IDLE: begin
               if (start_i && erase_i) begin
                  d.ph = PH_ERASE;
                  d.cnt = CW'(ERASE_CYC - 1);
               end else if (start_i) begin
                  d.ph = PH_PROG;
                  d.cnt = CW'(PROG_CYC - 1);
               end
            end
            PH_ERASE: begin
               if (q.cnt == '0) begin
                  d.ph = PH_PROG;
                  d.cnt = CW'(PROG_CYC - 1);
               end else begin
                  d.cnt = q.cnt - 1'b1;
               end
            end
            PH_PROG: begin
               if (q.cnt == '0) begin
                  d.ph = PH_IDLE;
                  d.done = 1'b1;
               end else begin
                  d.cnt = q.cnt - 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         q <= '{ph: PH_IDLE, cnt: '0, done: 1'b0};
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign busy_o = (q.ph != PH_IDLE);
   assign erasing_o = (q.ph == PH_ERASE);
   assign done_o = q.done;

   sequence s_go_erase;
      start_i && erase_i && (q.ph == PH_IDLE) && !abort_i;
   endsequence

   sequence s_erasing;
      erasing_o ##1 erasing_o;
   endsequence

   property p_erase_first;
      @(posedge clk_i) disable iff (reset_i || !ce_i || abort_i)
         s_go_erase |=> s_erasing;
   endproperty

   erase_before_prog_a: assert property (p_erase_first)
      else $error("auto-erase phase missing before programming");
endmodule // tmwc_nv_seq
`default_nettype wire

// File: src/tmwc_core.sv
`timescale 1ns/100ps
`default_nettype none
module tmwc_core #(
   parameter bit PRESET_EN = 1'b0,
   parameter logic [7:0] PRESET_ID = 8'h00, // arbitrary value
   parameter int unsigned ERASE_CYC = tmwc_pkg::ERASE_CYC,
   parameter int unsigned PROG_CYC = tmwc_pkg::PROG_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic power_fail_i,
   input wire tmwc_pkg::tmwc_req_t req_i,
   output tmwc_pkg::tmwc_rsp_t rsp_o,
   output logic [7:0] tag_select_id_o,
   output logic [15:0] lock_state_o
);
   typedef struct packed {
      logic [15:0][31:0] mem;
      logic [31:0] sys;
      logic [15:0] lock;
      logic [7:0] sel_id;
      logic [7:0] lfsr;
      logic [2:0] pf_sync;
      logic pf;
      logic busy;
      logic pend_sys;
      logic [3:0] pend_addr;
      logic [31:0] pend_data;
      tmwc_pkg::tmwc_rsp_t rsp;
   } tmwc_core_t;

   tmwc_core_t q;
   tmwc_core_t d;

   logic acc;
   logic erase;
   logic start;
   logic [31:0] wval;
   logic [3:0] wa;
   logic seq_done;
   logic wr_req;

   // lock bit at zero protects its block
   function automatic logic blk_locked(input logic [15:0] lk, input logic [3:0] a);
      return !lk[a];
   endfunction

   function automatic logic is_counter(input logic [7:0] a);
      return (a == tmwc_pkg::CNT_A_ADDR) || (a == tmwc_pkg::CNT_B_ADDR);
   endfunction

   // shipped block 255: all ones, low byte replaced by the fixed identifier when PRESET_EN is set
   function automatic logic [31:0] sys_reset();
      logic [31:0] s;
      s = tmwc_pkg::SYS_RST;
      if (PRESET_EN) begin
         s[tmwc_pkg::ID_MSB:0] = PRESET_ID;
      end
      return s;
   endfunction

   localparam logic [31:0] SYS_INIT = sys_reset();
   localparam logic [7:0] ID_INIT = PRESET_EN ? PRESET_ID : tmwc_pkg::ID_SEED;
   localparam logic [15:0][31:0] MEM_INIT = tmwc_pkg::tmwc_factory_mem();

   assign wa = req_i.addr[3:0];
   assign wr_req = req_i.valid && (req_i.op == tmwc_pkg::OP_WRITE);

   // write admission: which blocks may change and to what
   always_comb begin
      acc = 1'b0;
      erase = 1'b0;
      wval = req_i.data;
      if (req_i.addr == tmwc_pkg::SYS_ADDR) begin
         wval = q.sys & req_i.data;
         wval[tmwc_pkg::FACTORY_BIT] = q.sys[tmwc_pkg::FACTORY_BIT];
         if (PRESET_EN) begin
            wval[tmwc_pkg::ID_MSB:0] = q.sys[tmwc_pkg::ID_MSB:0];
         end
         acc = (q.sys != '0);
      end else if (req_i.addr < 8'(tmwc_pkg::NBLK)) begin
         if (blk_locked(q.lock, wa)) begin
            acc = 1'b0;
         end else if (is_counter(req_i.addr)) begin
            acc = (req_i.data < q.mem[wa]);
         end else begin
            acc = 1'b1;
            erase = (req_i.addr >= tmwc_pkg::AUTO_ERASE_LO);
         end
      end
   end

   // a new cycle may start only when idle and the supply is good
   assign start = wr_req && !q.busy && !q.pf && acc;

   // next state of the whole block
   always_comb begin
      d = q;
      d.rsp.rd_valid = 1'b0;
      d.rsp.wr_done = 1'b0;
      d.rsp.sel_match = 1'b0;
      d.lfsr = {q.lfsr[6:0], q.lfsr[7] ^ q.lfsr[5] ^ q.lfsr[4] ^ q.lfsr[3]};
      // power-fail pin: three flops, change taken when last two agree
      d.pf_sync = {q.pf_sync[1:0], power_fail_i};
      if (q.pf_sync[1] == q.pf_sync[2]) begin
         d.pf = q.pf_sync[2];
      end
      // new value is held aside until the cycle ends; tearing drops it
      if (q.busy && q.pf) begin
         d.busy = 1'b0;
      end else if (q.busy && seq_done) begin
         if (q.pend_sys) begin
            d.sys = q.pend_data;
         end else begin
            d.mem[q.pend_addr] = q.pend_data;
         end
         d.busy = 1'b0;
         d.rsp.wr_done = 1'b1;
      end
      if (req_i.valid) begin
         unique case (req_i.op)
            tmwc_pkg::OP_READ: begin
               d.rsp.rd_valid = 1'b1;
               if (req_i.addr == tmwc_pkg::SYS_ADDR) begin
                  d.rsp.rd_data = q.sys;
               end else if (req_i.addr < 8'(tmwc_pkg::NBLK)) begin
                  d.rsp.rd_data = q.mem[wa];
               end else begin
                  d.rsp.rd_data = '0;
               end
            end
            tmwc_pkg::OP_WRITE: begin
               if (start) begin
                  d.busy = 1'b1;
                  d.pend_sys = (req_i.addr == tmwc_pkg::SYS_ADDR);
                  d.pend_addr = wa;
                  d.pend_data = wval;
               end else if (!q.busy && !q.pf) begin
                  d.rsp.wr_done = 1'b1;
               end
            end
            tmwc_pkg::OP_SELECT: begin
               if (req_i.data[tmwc_pkg::ID_MSB:0] == q.sel_id) begin
                  d.lock = q.sys[tmwc_pkg::LOCK_MSB:tmwc_pkg::LOCK_LSB];
                  d.rsp.sel_match = 1'b1;
               end
            end
            tmwc_pkg::OP_NEW_ID: begin
               if (!PRESET_EN) begin
                  d.sel_id = q.lfsr;
               end
            end
            default: begin
            end
         endcase
      end
      d.rsp.busy = d.busy;
   end

   // nonvolatile contents reset to shipping values; pf starts clear
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         q.mem <= MEM_INIT;
         q.sys <= SYS_INIT;
         q.lock <= SYS_INIT[tmwc_pkg::LOCK_MSB:tmwc_pkg::LOCK_LSB];
         q.sel_id <= ID_INIT;
         q.lfsr <= tmwc_pkg::ID_SEED;
         q.pf_sync <= 3'h0;
         q.pf <= 1'b0;
         q.busy <= 1'b0;
         q.pend_sys <= 1'b0;
         q.pend_addr <= 4'h0;
         q.pend_data <= 32'h0;
         q.rsp <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   tmwc_nv_seq #(
      .ERASE_CYC(ERASE_CYC),
      .PROG_CYC(PROG_CYC)
   ) u_seq (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .start_i(start),
      .erase_i(erase),
      .abort_i(q.pf),
      .busy_o(),
      .erasing_o(),
      .done_o(seq_done)
   );

   assign rsp_o = q.rsp;
   assign tag_select_id_o = q.sel_id;
   assign lock_state_o = q.lock;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i || !ce_i);

   locked_write_a: assert property (
      wr_req && !q.busy && req_i.addr < 8'(tmwc_pkg::NBLK) && blk_locked(q.lock, wa)
      |=> !q.busy && q.mem == $past(q.mem))
      else $error("write to protected block was not ignored");

   count_reject_a: assert property (
      wr_req && !q.busy && !q.pf && is_counter(req_i.addr) && req_i.data >= q.mem[wa]
      |=> !q.busy && q.rsp.wr_done)
      else $error("counter accepted a value not lower");

   count_accept_a: assert property (
      wr_req && !q.busy && !q.pf && is_counter(req_i.addr)
      && !blk_locked(q.lock, wa) && req_i.data < q.mem[wa]
      |=> q.busy && q.pend_data == $past(req_i.data))
      else $error("counter decrement not started");

   sys_no_rise_a: assert property (
      (q.sys & ~$past(q.sys)) == '0)
      else $error("system block bit rose from zero");

   sys_empty_a: assert property (
      wr_req && !q.busy && req_i.addr == tmwc_pkg::SYS_ADDR && q.sys == '0
      |=> !q.busy)
      else $error("empty system block accepted a write");

   lock_load_a: assert property (
      req_i.valid && req_i.op == tmwc_pkg::OP_SELECT
      && req_i.data[tmwc_pkg::ID_MSB:0] == q.sel_id
      |=> q.rsp.sel_match && q.lock == $past(q.sys[tmwc_pkg::LOCK_MSB:tmwc_pkg::LOCK_LSB]))
      else $error("locks not loaded at matching select");

   lock_hold_a: assert property (
      !(req_i.valid && req_i.op == tmwc_pkg::OP_SELECT) |=> $stable(q.lock))
      else $error("locks changed without a select");

   tear_keep_a: assert property (
      q.busy && q.pf |=> !q.busy && q.mem == $past(q.mem) && q.sys == $past(q.sys))
      else $error("torn write changed stored data");

   count_empty_a: assert property (
      q.mem[tmwc_pkg::CNT_A_ADDR[3:0]] == '0 |=> q.mem[tmwc_pkg::CNT_A_ADDR[3:0]] == '0)
      else $error("exhausted counter reloaded");

   count_b_empty_a: assert property (
      q.mem[tmwc_pkg::CNT_B_ADDR[3:0]] == '0 |=> q.mem[tmwc_pkg::CNT_B_ADDR[3:0]] == '0)
      else $error("exhausted second counter reloaded");

   preset_id_a: assert property (
      PRESET_EN |-> q.sel_id == PRESET_ID && q.sys[tmwc_pkg::ID_MSB:0] == PRESET_ID)
      else $error("fixed identifier not in use");

   read_any_a: assert property (
      req_i.valid && req_i.op == tmwc_pkg::OP_READ |=> q.rsp.rd_valid)
      else $error("read not answered");

   commit_a: assert property (
      q.busy && seq_done && !q.pf && !q.pend_sys
      |=> q.rsp.wr_done && q.mem[$past(q.pend_addr)] == $past(q.pend_data))
      else $error("accepted write not committed whole");
endmodule // tmwc_core
`default_nettype wire

// File: verif/tmwc_reader.sv
`timescale 1ns/100ps
`default_nettype none
module tmwc_reader (
   input wire logic clk_i,
   input wire tmwc_pkg::tmwc_rsp_t rsp_i,
   output tmwc_pkg::tmwc_req_t req_o
);
   initial req_o = '0;

   // one request pulse, then a bounded wait for its answer flag
   task automatic xfer(input tmwc_pkg::tmwc_op_t op, input logic [7:0] a,
      input logic [31:0] d, input int gap, output int k, output logic [31:0] q);
      repeat (gap) @(negedge clk_i); // slow reader leaves idle cycles
      @(negedge clk_i);
      req_o = '{1'b1, op, a, d};
      @(negedge clk_i);
      // released lines show the inverse, never the stale request
      req_o = '{1'b0, tmwc_pkg::OP_NONE, ~a, ~d};
      k = 0;
      while (k < 40 && (rsp_i.rd_valid | rsp_i.wr_done | rsp_i.sel_match) !== 1'b1) begin
         @(negedge clk_i);
         k++;
      end
      q = rsp_i.rd_data;
   endtask
endmodule // tmwc_reader
`default_nettype wire

// File: verif/tmwc_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tmwc_tb_top;
   typedef struct {
      tmwc_pkg::tmwc_op_t op;
      logic [7:0] a;
      logic [31:0] d;
      int k;
      logic [31:0] q;
   } tmwc_row_t;

   logic clk_i;
   logic reset_i;
   logic power_fail_i;
   tmwc_pkg::tmwc_req_t req;
   tmwc_pkg::tmwc_rsp_t rsp;
   logic [7:0] sel_id;
   logic [15:0] lock;
   tmwc_row_t rows[$];
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int k;
   logic [31:0] q;

   // short nonvolatile timing keeps the run brief: counter 6, user block 8
   tmwc_core #(.ERASE_CYC(2), .PROG_CYC(6)) dut (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(1'b1),
      .power_fail_i(power_fail_i),
      .req_i(req),
      .rsp_o(rsp),
      .tag_select_id_o(sel_id),
      .lock_state_o(lock)
   );

   tmwc_reader rdr (
      .clk_i(clk_i),
      .rsp_i(rsp),
      .req_o(req)
   );

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // hang guard, well above the expected run length
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // row builders: k is answer delay, -1 when not judged
   function automatic void w(logic [7:0] a, logic [31:0] d, int k);
      rows.push_back('{tmwc_pkg::OP_WRITE, a, d, k, 32'h0});
   endfunction
   function automatic void r(logic [7:0] a, logic [31:0] q);
      rows.push_back('{tmwc_pkg::OP_READ, a, 32'h0, 0, q});
   endfunction
   function automatic void s(logic [7:0] id, int k);
      rows.push_back('{tmwc_pkg::OP_SELECT, 8'hff, {24'h0, id}, k, 32'h0});
   endfunction

   initial begin
      reset_i = 1'b1;
      power_fail_i = 1'b0;
      r(8'h05, 32'hffff_fffe);
      r(8'h06, 32'hffff_ffff);
      w(8'h05, 32'hffff_fffd, 7);
      r(8'h05, 32'hffff_fffd);
      w(8'h05, 32'hffff_fff5, 7);
      w(8'h05, 32'hffff_fff6, 0);
      w(8'h05, 32'hffff_fff5, 0);
      r(8'h05, 32'hffff_fff5);
      w(8'h06, 32'h0, 7);
      w(8'h06, 32'h1, 0);
      r(8'h06, 32'h0);
      w(8'h08, 32'h1234_5678, 9);
      r(8'h08, 32'h1234_5678);
      w(8'h02, 32'ha5a5_a5a5, 7);
      r(8'h02, 32'ha5a5_a5a5);
      w(8'h14, 32'h1, 0);
      r(8'h14, 32'h0);
      w(8'hff, 32'hfeff_ffff, 7);
      w(8'h08, 32'h0000_1111, 9);
      r(8'h08, 32'h0000_1111);
      s(tmwc_pkg::ID_SEED, 0);
      w(8'h08, 32'h2222_2222, 0);
      r(8'h08, 32'h0000_1111);
      w(8'hff, 32'hffff_ffff, 7);
      s(tmwc_pkg::ID_SEED, 0);
      w(8'h08, 32'h3333_3333, 0);
      r(8'hff, 32'hfeff_ffff);
      s(8'h00, 40);
      w(8'hff, 32'hfedf_ffff, 7);
      s(tmwc_pkg::ID_SEED, 0);
      w(8'h05, 32'h0, 0);
      r(8'h05, 32'hffff_fff5);
      w(8'hff, 32'h0, 7);
      r(8'hff, 32'h0000_8000);
      s(tmwc_pkg::ID_SEED, 0);
      w(8'h09, 32'h1, 0);
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      // ordinary rows, with a varying idle gap between requests
      foreach (rows[i]) begin
         rdr.xfer(rows[i].op, rows[i].a, rows[i].d, i % 3, k, q);
         if (rows[i].k >= 0) begin
            chk(32'(k), 32'(rows[i].k));
         end
         if (rows[i].op == tmwc_pkg::OP_READ) begin
            chk(q, rows[i].q);
         end
      end
      chk({16'h0, lock}, 32'h0);
      // second reset in mid-run restores shipping state
      @(negedge clk_i);
      reset_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk({24'h0, sel_id}, {24'h0, tmwc_pkg::ID_SEED});
      chk({16'h0, lock}, 32'h0000_ffff);
      chk({31'h0, rsp.busy}, 32'h0);
      reset_i = 1'b0;
      // power lost during counter programming: no done, old value kept
      fork
         rdr.xfer(tmwc_pkg::OP_WRITE, 8'h05, 32'h0, 0, k, q);
         begin
            repeat (2) @(negedge clk_i);
            power_fail_i = 1'b1;
         end
      join
      chk(32'(k), 32'd40);
      power_fail_i = 1'b0;
      repeat (5) @(negedge clk_i);
      rdr.xfer(tmwc_pkg::OP_READ, 8'h05, 32'h0, 0, k, q);
      chk(q, 32'hffff_fffe);
      // fresh identifier gives no answer pulse; the tag then selects by it
      rdr.xfer(tmwc_pkg::OP_NEW_ID, 8'h00, 32'h0, 0, k, q);
      chk(32'(k), 32'd40);
      chk({31'h0, sel_id == tmwc_pkg::ID_SEED}, 32'h0);
      rdr.xfer(tmwc_pkg::OP_SELECT, 8'hff, {24'h0, sel_id}, 0, k, q);
      chk(32'(k), 32'd0);
      end_of_test();
   end
endmodule // tmwc_tb_top
`default_nettype wire
